// file: rtl/tbt_pkg.sv
package tbt_pkg;

  // ****************************************
  // widths and counts
  // ****************************************
  localparam int unsigned TBT_CW    = 16;  // raw count width
  localparam int unsigned TBT_SW    = 17;  // signed signal width
  localparam int unsigned TBT_NFREQ = 3;   // sense frequencies in mfs mode

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] TBT_OFF_CTRL   = 8'h00;
  localparam logic [7:0] TBT_OFF_FINGER = 8'h04;
  localparam logic [7:0] TBT_OFF_HYST   = 8'h08;
  localparam logic [7:0] TBT_OFF_NOISE  = 8'h0c;
  localparam logic [7:0] TBT_OFF_NNOISE = 8'h10;
  localparam logic [7:0] TBT_OFF_LOWRST = 8'h14;
  localparam logic [7:0] TBT_OFF_DEBNC  = 8'h18;
  localparam logic [7:0] TBT_OFF_STATUS = 8'h1c;
  localparam logic [7:0] TBT_OFF_BASE   = 8'h20;
  localparam logic [7:0] TBT_OFF_SIGNAL = 8'h24;

  // ****************************************
  // control field positions
  // ****************************************
  localparam int unsigned TBT_CTRL_EN    = 0;
  localparam int unsigned TBT_CTRL_AUTO  = 1;
  localparam int unsigned TBT_CTRL_MFS   = 2;
  localparam int unsigned TBT_CTRL_SHLSB = 4;  // shift field, 3 bits

  // ****************************************
  // reset values
  // ****************************************
  localparam logic        TBT_RST_EN     = 1'b0;
  localparam logic        TBT_RST_AUTO   = 1'b0;
  localparam logic        TBT_RST_MFS    = 1'b0;
  localparam logic [2:0]  TBT_RST_SHIFT  = 3'h2;
  localparam logic [15:0] TBT_RST_FINGER = 16'h0050;
  localparam logic [15:0] TBT_RST_HYST   = 16'h000a;
  localparam logic [15:0] TBT_RST_NOISE  = 16'h0028;
  localparam logic [15:0] TBT_RST_NNOISE = 16'h0028;
  localparam logic [7:0]  TBT_RST_LOWRST = 8'h1e;
  localparam logic [7:0]  TBT_RST_DEBNC  = 8'h03;

  // ****************************************
  // state of the top module
  // ****************************************
  typedef struct packed {
    logic                  en;
    logic                  auto_rst;
    logic                  mfs;
    logic [2:0]            shift;
    logic [15:0]           finger;
    logic [15:0]           hyst;
    logic [15:0]           noise;
    logic [15:0]           nnoise;
    logic [7:0]            lowrst;
    logic [7:0]            debnc;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
    logic [2:0][15:0]      bl;
    logic [2:0]            init;
    logic [2:0][7:0]       lowcnt;
    logic [2:0][16:0]      dsig;
    logic [1:0]            fsel;
    logic [7:0]            runcnt;
    logic                  on;
    logic [16:0]           sig_out;
    logic [15:0]           bl_out;
  } tbt_state_t;

  // recursive average step toward the raw count
  function automatic logic [15:0] tbt_lpf(input logic [15:0] bl,
                                          input logic [15:0] raw,
                                          input logic [2:0]  sh);
    logic signed [17:0] dif;
    logic signed [17:0] stp;
    dif = $signed({2'b00, raw}) - $signed({2'b00, bl});
    stp = dif >>> sh;
    return 16'(18'($signed({2'b00, bl}) + stp));
  endfunction

endpackage

// file: rtl/tbt_median3.sv
// median of three signed difference counts
module tbt_median3 (
  // candidates
  input  wire logic signed [16:0] a,
  input  wire logic signed [16:0] b,
  input  wire logic signed [16:0] c,
  // result
  output logic signed [16:0]      m
);
  import tbt_pkg::*;

  // pick the one that is neither smallest nor largest
  always_comb begin
    // both orders tested so ties still land on the middle value
    if (((a >= b) && (a <= c)) || ((a <= b) && (a >= c))) begin
      m = a;
    end else if (((b >= a) && (b <= c)) || ((b <= a) && (b >= c))) begin
      m = b;
    end else begin
      m = c;
    end
  end

endmodule // tbt_median3

// file: rtl/tbt_onoff.sv
// next touch state and run count from one signal value
module tbt_onoff (
  // current decision state
  input  wire logic signed [16:0] sig,
  input  wire logic [7:0]         run,
  input  wire logic               on,
  // thresholds
  input  wire logic [15:0]        finger,
  input  wire logic [15:0]        hyst,
  input  wire logic [7:0]         debnc,
  // next state
  output logic [7:0]              nxt_run,
  output logic                    nxt_on
);
  import tbt_pkg::*;

  logic signed [17:0] hi_lim;
  logic signed [17:0] lo_lim;
  logic signed [17:0] sig_x;

  // limits kept signed so a bad setting cannot wrap
  assign hi_lim = $signed({2'b00, finger}) + $signed({2'b00, hyst});
  assign lo_lim = $signed({2'b00, finger}) - $signed({2'b00, hyst});
  assign sig_x  = 18'(sig);

  always_comb begin
    nxt_run = run;
    nxt_on  = on;
    if (sig_x >= hi_lim) begin
      // saturate so a long touch does not wrap the run
      nxt_run = (run == 8'hff) ? run : run + 8'h01;
      if (nxt_run >= debnc) begin
        nxt_on = 1'b1;
      end                                    // else keeps its state
    end else if (sig_x <= lo_lim) begin
      nxt_run = 8'h00;
      nxt_on  = 1'b0;
    end else begin
      // inside the band: hold state, run must restart
      nxt_run = 8'h00;
    end
  end

endmodule // tbt_onoff

// file: rtl/tbt_top.sv
// Operation
// - on after debounce scans above high limit
// - off when signal at or below low limit
// - stay off while run shorter than debounce
// - hold baseline when raw above noise band
// - freeze baseline on low raw counts
// - count low samples, then load raw count
// - first raw count initialises the baseline
// - no auto reset: update only inside band
// - auto reset: update whenever not low
// - mfs: one difference per each of three frequencies
// - mfs: median of three drives state decision
// - signal is raw count minus baseline
// - baseline is low-pass filtered raw count
//
// Our own choices: the APB slave port and the register offsets.
module tbt_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // raw count source
  input  wire logic        raw_valid,
  input  wire logic [15:0] raw_count,
  output logic [1:0]       freq_sel,
  // results
  output logic             sensor_on,
  output logic [15:0]      baseline,
  output logic [16:0]      signal
);
  import tbt_pkg::*;

  // ****************************************
  // overview
  // ****************************************
  // each enabled raw sample is handled in the single cycle of its strobe:
  // the signal is taken against the baseline as it stood before the
  // sample, then the baseline of that frequency slot moves, freezes or
  // reloads, and the touch decision steps once per complete scan set.
  // without mfs every sample is its own set and uses slot zero only.
  // thresholds are plain unsigned counts; software must keep hysteresis
  // below the finger threshold and the noise band below the lower limit,
  // the logic does not police either setting.
  // the status word shows the slot zero low count only; other slots are
  // visible through their effect on the baseline.
  // mfs should be toggled only at a slot zero boundary, otherwise one
  // scan set mixes samples taken under two different modes.

  // ****************************************
  // state
  // ****************************************
  tbt_state_t st_ff;
  tbt_state_t nxt_st;

  // ****************************************
  // per-sample arithmetic
  // ****************************************
  logic               scan;
  logic [1:0]         k;
  logic [15:0]        bl_k;
  logic signed [17:0] dif;
  logic signed [16:0] dk;
  logic               low;
  logic               in_band;
  logic               decide;
  logic signed [16:0] med;
  logic signed [16:0] dec_sig;
  logic [7:0]         nxt_run;
  logic               nxt_on;

  // a sample only counts while the block is enabled
  assign scan = raw_valid & st_ff.en;
  // without mfs every sample belongs to slot zero
  assign k    = st_ff.mfs ? st_ff.fsel : 2'h0;
  assign bl_k = st_ff.bl[k];
  // 18 bits: two unsigned 16-bit counts cannot overflow the difference
  assign dif  = $signed({2'b00, raw_count}) - $signed({2'b00, bl_k});
  // the first sample sets the baseline, so its signal is zero
  assign dk   = st_ff.init[k] ? 17'(dif) : 17'sh0;
  // strict below the negative band, inclusive at the top of the band
  assign low  = dif < -$signed({2'b00, st_ff.nnoise});
  assign in_band = dif <= $signed({2'b00, st_ff.noise});
  // mfs decides once the third frequency has been scanned
  assign decide  = scan & (~st_ff.mfs | (st_ff.fsel == 2'h2));
  assign dec_sig = st_ff.mfs ? med : dk;

  // median across the three frequency slots
  // slot two is taken live, so the decision needs no extra cycle
  tbt_median3 u_med (
    .a (st_ff.dsig[0]),
    .b (st_ff.dsig[1]),
    .c (dk),
    .m (med)
  );

  // touch decision with hysteresis and debounce
  // fed the median in mfs, the plain slot zero signal otherwise
  tbt_onoff u_onoff (
    .sig     (dec_sig),
    .run     (st_ff.runcnt),
    .on      (st_ff.on),
    .finger  (st_ff.finger),
    .hyst    (st_ff.hyst),
    .debnc   (st_ff.debnc),
    .nxt_run (nxt_run),
    .nxt_on  (nxt_on)
  );

  // ****************************************
  // next state
  // ****************************************
  // one process: bus, baseline tracking and decision
  always_comb begin
    logic        acc;
    logic        hit;
    logic [31:0] rd;
    logic [7:0]  lc;
    acc = psel & penable;
    hit = 1'b1;
    rd  = 32'h0;
    lc  = 8'h0;
    nxt_st = st_ff;

    // ****************************************
    // register bus
    // ****************************************
    // bus: one wait state, data and error set in the first cycle;
    // the read word is captured one edge early so prdata comes
    // straight from a flop, at the cost of a fixed extra cycle
    nxt_st.pready  = acc & ~st_ff.pready;
    nxt_st.pslverr = 1'b0;
    if (paddr == TBT_OFF_CTRL) begin
      rd[TBT_CTRL_EN]   = st_ff.en;
      rd[TBT_CTRL_AUTO] = st_ff.auto_rst;
      rd[TBT_CTRL_MFS]  = st_ff.mfs;
      rd[TBT_CTRL_SHLSB +: 3] = st_ff.shift;
    end else if (paddr == TBT_OFF_FINGER) begin
      rd[15:0] = st_ff.finger;
    end else if (paddr == TBT_OFF_HYST) begin
      rd[15:0] = st_ff.hyst;
    end else if (paddr == TBT_OFF_NOISE) begin
      rd[15:0] = st_ff.noise;
    end else if (paddr == TBT_OFF_NNOISE) begin
      rd[15:0] = st_ff.nnoise;
    end else if (paddr == TBT_OFF_LOWRST) begin
      rd[7:0] = st_ff.lowrst;
    end else if (paddr == TBT_OFF_DEBNC) begin
      rd[7:0] = st_ff.debnc;
    end else if (paddr == TBT_OFF_STATUS) begin
      rd[0]    = st_ff.on;
      rd[3:1]  = st_ff.init;
      rd[5:4]  = st_ff.fsel;
      rd[15:8] = st_ff.runcnt;
      rd[23:16] = st_ff.lowcnt[0];
    end else if (paddr == TBT_OFF_BASE) begin
      rd[15:0] = st_ff.bl_out;
    end else if (paddr == TBT_OFF_SIGNAL) begin
      rd[16:0] = st_ff.sig_out;
    end else begin
      hit = 1'b0;
    end
    if (acc & ~st_ff.pready) begin
      nxt_st.prdata  = pwrite ? 32'h0 : rd;
      nxt_st.pslverr = ~hit;
    end

    // writes land on the completing edge; status words are read only
    // a write to an unmapped word only raises the error, nothing moves
    if (acc & st_ff.pready & pwrite) begin
      if (paddr == TBT_OFF_CTRL) begin
        nxt_st.en       = pwdata[TBT_CTRL_EN];
        nxt_st.auto_rst = pwdata[TBT_CTRL_AUTO];
        nxt_st.mfs      = pwdata[TBT_CTRL_MFS];
        nxt_st.shift    = pwdata[TBT_CTRL_SHLSB +: 3];
      end else if (paddr == TBT_OFF_FINGER) begin
        nxt_st.finger = pwdata[15:0];
      end else if (paddr == TBT_OFF_HYST) begin
        nxt_st.hyst = pwdata[15:0];
      end else if (paddr == TBT_OFF_NOISE) begin
        nxt_st.noise = pwdata[15:0];
      end else if (paddr == TBT_OFF_NNOISE) begin
        nxt_st.nnoise = pwdata[15:0];
      end else if (paddr == TBT_OFF_LOWRST) begin
        nxt_st.lowrst = pwdata[7:0];
      end else if (paddr == TBT_OFF_DEBNC) begin
        nxt_st.debnc = pwdata[7:0];
      end
    end

    // ****************************************
    // baseline tracking
    // ****************************************
    // baseline tracking for the slot of this sample;
    // a low run is counted per slot, so negative noise at one
    // frequency cannot reload the baseline of another
    if (scan) begin
      nxt_st.dsig[k] = dk;
      if (!st_ff.init[k]) begin
        // touch at startup is taken as baseline too
        nxt_st.bl[k]     = raw_count;
        nxt_st.init[k]   = 1'b1;
        nxt_st.lowcnt[k] = 8'h00;
      end else if (low) begin
        lc = (st_ff.lowcnt[k] == 8'hff) ? 8'hff
                                        : st_ff.lowcnt[k] + 8'h01;
        if (lc >= st_ff.lowrst) begin
          nxt_st.bl[k]     = raw_count;
          nxt_st.lowcnt[k] = 8'h00;
        end else begin
          nxt_st.lowcnt[k] = lc;
        end
      end else begin
        // a sample inside or above the band breaks the low run
        nxt_st.lowcnt[k] = 8'h00;
        if (st_ff.auto_rst | in_band) begin
          nxt_st.bl[k] = tbt_lpf(bl_k, raw_count, st_ff.shift);
        end
      end
      // step the sense frequency only in mfs mode
      if (st_ff.mfs) begin
        nxt_st.fsel = (st_ff.fsel == 2'h2) ? 2'h0 : st_ff.fsel + 2'h1;
      end else begin
        nxt_st.fsel = 2'h0;
      end
      nxt_st.bl_out = nxt_st.bl[k];
    end

    // ****************************************
    // touch decision
    // ****************************************
    // decision once per full scan set;
    // in mfs the run counts scan sets, not single samples
    if (decide) begin
      nxt_st.runcnt  = nxt_run;
      nxt_st.on      = nxt_on;
      nxt_st.sig_out = dec_sig;
    end

    // disabling restarts tracking from the next first sample;
    // baselines keep their old value but are reloaded on re-enable
    if (!st_ff.en) begin
      nxt_st.init   = 3'h0;
      nxt_st.lowcnt = '0;
      nxt_st.fsel   = 2'h0;
      nxt_st.runcnt = 8'h00;
      nxt_st.on     = 1'b0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // single flop bank for all state
  // config resets to package values so software reads sane defaults
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_ff          <= '0;
      st_ff.en       <= TBT_RST_EN;
      st_ff.auto_rst <= TBT_RST_AUTO;
      st_ff.mfs      <= TBT_RST_MFS;
      st_ff.shift    <= TBT_RST_SHIFT;
      st_ff.finger   <= TBT_RST_FINGER;
      st_ff.hyst     <= TBT_RST_HYST;
      st_ff.noise    <= TBT_RST_NOISE;
      st_ff.nnoise   <= TBT_RST_NNOISE;
      st_ff.lowrst   <= TBT_RST_LOWRST;
      st_ff.debnc    <= TBT_RST_DEBNC;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // outputs straight from the flop bank
  // no logic between flop and pin, so outputs cannot glitch
  assign prdata    = st_ff.prdata;
  assign pready    = st_ff.pready;
  assign pslverr   = st_ff.pslverr;
  assign freq_sel  = st_ff.fsel;
  assign sensor_on = st_ff.on;
  assign baseline  = st_ff.bl_out;
  assign signal    = st_ff.sig_out;

endmodule // tbt_top

// file: sim/tbt_top_monitor.sv
module tbt_top_monitor (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rstn,
  // apb slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // raw count source
  input wire logic        raw_valid,
  input wire logic [15:0] raw_count,
  input wire logic [1:0]  freq_sel,
  // results
  input wire logic        sensor_on,
  input wire logic [15:0] baseline,
  input wire logic [16:0] signal
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // one clock domain, checks off in reset
  // ****
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_PREADY_ANSWER: assert property (psel && penable && !pready |=> pready)
    else $error("no answer in the cycle after access");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_HOLD_NO_SAMPLE: assert property (
    !raw_valid |=> $stable(baseline) && $stable(signal))
    else $error("baseline or signal moved without a sample");
  AST_ON_BY_SAMPLE: assert property (
    $rose(sensor_on) |-> $past(raw_valid))
    else $error("touch state rose without a sample");
  AST_ON_POSITIVE: assert property (
    $rose(sensor_on) |-> !signal[16] && signal != 17'h0)
    else $error("touch state rose on a non-positive signal");
  AST_OFF_CAUSE: assert property (
    $fell(sensor_on) |-> $past(raw_valid) || $past(pready && pwrite, 2))
    else $error("touch state fell without a cause");
  AST_SLOT_RANGE: assert property (freq_sel != 2'h3)
    else $error("frequency slot out of range");
  AST_SLOT_STEP: assert property (
    !$stable(freq_sel) |-> $past(raw_valid) || $past(pready && pwrite, 2))
    else $error("frequency slot moved without a sample");
  AST_SLOT_NEXT: assert property (
    raw_valid && freq_sel == 2'h1 |=> freq_sel == 2'h2)
    else $error("slot 1 not followed by slot 2");
  AST_SLOT_WRAP: assert property (
    raw_valid && freq_sel == 2'h2 |=> freq_sel == 2'h0)
    else $error("slot 2 not followed by slot 0");

  // main scenarios reached
  COV_ON: cover property ($rose(sensor_on));
  COV_ERR: cover property (pslverr);
  COV_SLOT2: cover property (raw_valid && freq_sel == 2'h2);
endmodule // tbt_top_monitor

bind tbt_top tbt_top_monitor u_mon (.mclk(mclk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .raw_valid(raw_valid), .raw_count(raw_count), .freq_sel(freq_sel),
  .sensor_on(sensor_on), .baseline(baseline), .signal(signal));

// file: sim/tbt_src.sv
module tbt_src (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rstn,
  // request from the bench
  input  wire logic             go,
  input  wire logic [2:0][15:0] slot_val,
  // scan converter side
  input  wire logic [1:0]       freq_sel,
  output logic                  raw_valid,
  output logic [15:0]           raw_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // one count per scan, at the slot the block asks for;
  // the stale count is inverted so nothing relies on it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      raw_valid <= 1'b0;
      raw_count <= 16'h0;
    end else if (go) begin
      raw_valid <= 1'b1;
      raw_count <= slot_val[freq_sel];
    end else begin
      raw_valid <= 1'b0;
      raw_count <= ~raw_count;
    end
  end
endmodule // tbt_src

// file: sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tbt_pkg::*;
  logic mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, go = 1'b0, pready, pslverr, raw_valid, sensor_on;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [15:0] raw_count, baseline;
  logic [16:0] signal;
  logic [1:0] freq_sel;
  logic [2:0][15:0] sv = '0;
  logic e;
  int error_cnt = 0, check_count = 0;
  logic [7:0] ra[10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
                         8'h1c, 8'h20, 8'h24};
  logic [31:0] rv[10] = '{32'h20, 32'h50, 32'h0a, 32'h28, 32'h28, 32'h1e,
                          32'h03, 32'h0, 32'h0, 32'h0};

  always #5 mclk = ~mclk;

  tbt_top uut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .raw_valid(raw_valid),
    .raw_count(raw_count), .freq_sel(freq_sel), .sensor_on(sensor_on),
    .baseline(baseline), .signal(signal));
  tbt_src u_src (.mclk(mclk), .rstn(rstn), .go(go), .slot_val(sv),
    .freq_sel(freq_sel), .raw_valid(raw_valid), .raw_count(raw_count));

  // ****
  // tasks
  // ****
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // setup, access until pready, then release on its own edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("ERROR %0t bus timeout", $time);
      end_sim;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // one scan; outputs are read one edge after the sample is taken
  task automatic scan(input logic [2:0][15:0] v);
    sv <= v;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic outs(input int b, input int s, input logic o);
    chk(32'(baseline), 32'(b));
    chk(32'(signal), {15'h0, 17'(s)});
    chk(32'(sensor_on), 32'(o));
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, ra[i], 32'h0);
      // defaults fit a touch of 100 counts; low reset and control are rewritten later
      chk(q, rv[i]);
      chk(32'(e), 32'h0);
    end
    apb(1'b1, TBT_OFF_BASE, 32'h1234);
    apb(1'b0, TBT_OFF_BASE, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, 8'h40, 32'h5);
    chk(32'(e), 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    chk(32'(e), 32'h1);
    $display("test registers done");
    apb(1'b1, TBT_OFF_LOWRST, 32'h3);
    apb(1'b1, TBT_OFF_CTRL, 32'h21);
    scan({3{16'd1000}});
    outs(1000, 0, 1'b0);
    scan({3{16'd1020}});
    outs(1005, 20, 1'b0);
    for (int i = 0; i < 3; i++) begin
      scan({3{16'd1105}});
      outs(1005, 100, i == 2);
    end
    scan({3{16'd1005}});
    outs(1005, 0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      scan({3{16'd900}});
      outs(i == 2 ? 900 : 1005, -105, 1'b0);
    end
    $display("test baseline and state done");
    apb(1'b1, TBT_OFF_CTRL, 32'h23);
    scan({3{16'd1000}});
    outs(925, 100, 1'b0);
    $display("test auto reset done");
    apb(1'b1, TBT_OFF_CTRL, 32'h20);
    apb(1'b1, TBT_OFF_CTRL, 32'h25);
    for (int i = 0; i < 3; i++) begin
      scan({3{16'd1000}});
      chk(32'(freq_sel), 32'((i + 1) % 3));
    end
    for (int i = 0; i < 3; i++) scan({16'd1200, 16'd1010, 16'd1100});
    outs(1000, 100, 1'b0);
    for (int i = 0; i < 3; i++) scan({16'd1010, 16'd1102, 16'd1100});
    outs(1002, 100, 1'b0);
    $display("test median done");
    end_sim;
  end
endmodule // tb_top
